// >>> src/dgcfg_defines.svh
// Register offsets, field positions and reset values of the gain slice
`ifndef DGCFG_DEFINES_SVH
`define DGCFG_DEFINES_SVH
`define DGCFG_SEC_GAIN_ADDR   7'h6C
`define DGCFG_PRI_GAIN_ADDR   7'h6D
`define DGCFG_PHASE_LO_ADDR   7'h70
`define DGCFG_GAIN_RESET      8'hC2
`define DGCFG_PHASE_RESET     8'h00
`define DGCFG_SEL_ON_BIT      7
`define DGCFG_ANALOG_HI       6
`define DGCFG_ANALOG_LO       4
`define DGCFG_DIGITAL_HI      2
`define DGCFG_DIGITAL_LO      0
`endif

// >>> src/dgcfg_pkg.sv
// Types shared by the gain configuration slice
package dgcfg_pkg;
    typedef logic [7:0] dgcfg_byte_t;
    typedef logic [2:0] dgcfg_gain_t;
    typedef struct packed {
        dgcfg_byte_t sec_gain;
        dgcfg_byte_t pri_gain;
        dgcfg_byte_t phase_lo;
        dgcfg_byte_t rd_data;
    } dgcfg_state_s;
endpackage : dgcfg_pkg

// >>> src/dgcfg_regs.sv
// Detector gain registers for the two loops plus phase shift low byte
`timescale 1ns/1ns
`include "dgcfg_defines.svh"
module dgcfg_regs
    import dgcfg_pkg::*;
#(
    parameter int ADDR_W = 7
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              clk_en,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    input  wire logic [7:0]        wr_data,
    output logic      [7:0]        rd_data,
    input  wire logic              sec_analog_mode,
    input  wire logic              sec_ref_above_8k,
    input  wire logic              pri_analog_mode,
    input  wire logic              pri_ref_above_8k,
    output logic                   secondary_gain_select_on,
    output logic                   primary_gain_select_on,
    output logic                   sec_gain_valid,
    output logic      [2:0]        sec_gain,
    output logic                   pri_gain_valid,
    output logic      [2:0]        pri_gain,
    output logic      [7:0]        phase_shift_low
);
    // Offsets need seven address bits; narrower buses alias registers
    if (ADDR_W < 7) begin : g_bad_addr_w
        $error("ADDR_W must be at least 7");
    end

    dgcfg_state_s st_r;
    dgcfg_state_s st_nxt;

    // Gain choice for one loop from its register and locking mode
    function automatic logic [3:0] pick_gain(
        input dgcfg_byte_t r,
        input logic        analog,
        input logic        above_8k
    );
        logic [3:0] res;
        res = 4'h0;
        if (r[`DGCFG_SEL_ON_BIT]) begin
            if (!analog) begin
                res = {1'b1, r[`DGCFG_DIGITAL_HI:`DGCFG_DIGITAL_LO]};
            end else if (above_8k) begin
                res = {1'b1, r[`DGCFG_ANALOG_HI:`DGCFG_ANALOG_LO]};
            end
        end
        return res;
    endfunction : pick_gain

    always_comb begin
        st_nxt = st_r;
        if (wr_en) begin
            unique case (addr)
                ADDR_W'(`DGCFG_SEC_GAIN_ADDR): st_nxt.sec_gain = wr_data;
                ADDR_W'(`DGCFG_PRI_GAIN_ADDR): st_nxt.pri_gain = wr_data;
                ADDR_W'(`DGCFG_PHASE_LO_ADDR): st_nxt.phase_lo = wr_data;
                default: ;
            endcase
        end
        if (rd_en) begin
            // Unmapped addresses read as zero
            unique case (addr)
                ADDR_W'(`DGCFG_SEC_GAIN_ADDR): st_nxt.rd_data = st_r.sec_gain;
                ADDR_W'(`DGCFG_PRI_GAIN_ADDR): st_nxt.rd_data = st_r.pri_gain;
                ADDR_W'(`DGCFG_PHASE_LO_ADDR): st_nxt.rd_data = st_r.phase_lo;
                default: st_nxt.rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_r.sec_gain <= `DGCFG_GAIN_RESET;
            st_r.pri_gain <= `DGCFG_GAIN_RESET;
            st_r.phase_lo <= `DGCFG_PHASE_RESET;
            st_r.rd_data  <= 8'h00;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    logic [3:0] sec_pick;
    logic [3:0] pri_pick;
    assign sec_pick = pick_gain(st_r.sec_gain, sec_analog_mode,
                                sec_ref_above_8k);
    assign pri_pick = pick_gain(st_r.pri_gain, pri_analog_mode,
                                pri_ref_above_8k);

    assign rd_data                  = st_r.rd_data;
    assign phase_shift_low          = st_r.phase_lo;
    assign secondary_gain_select_on = st_r.sec_gain[`DGCFG_SEL_ON_BIT];
    assign primary_gain_select_on   = st_r.pri_gain[`DGCFG_SEL_ON_BIT];
    assign sec_gain_valid           = sec_pick[3];
    assign sec_gain                 = sec_pick[2:0];
    assign pri_gain_valid           = pri_pick[3];
    assign pri_gain                 = pri_pick[2:0];
endmodule : dgcfg_regs

// >>> testbench/dgcfg_checker.sv
// Port assertions for the detector gain slice
`timescale 1ns/1ns
module dgcfg_checker (
    input wire logic       clock, rst, clk_en, wr_en,
    input wire logic       secondary_gain_select_on, primary_gain_select_on,
    input wire logic       sec_gain_valid, pri_gain_valid,
    input wire logic       sec_analog_mode, sec_ref_above_8k,
    input wire logic [6:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic [2:0] sec_gain
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_gain_reset_on: assert property ($past(rst) |->
        secondary_gain_select_on && primary_gain_select_on) else $error("bad");
    a_select_write: assert property (clk_en && wr_en && addr == 7'h6C |=>
        secondary_gain_select_on == $past(wr_data[7])) else $error("bad");
    a_select_off: assert property (!secondary_gain_select_on |->
        !sec_gain_valid && sec_gain == 3'h0) else $error("bad");
    a_digital_used: assert property (secondary_gain_select_on &&
        !sec_analog_mode |-> sec_gain_valid) else $error("bad");
    a_analog_used: assert property (secondary_gain_select_on &&
        sec_analog_mode && sec_ref_above_8k |-> sec_gain_valid) else $error("bad");
    a_pri_off: assert property (!primary_gain_select_on |->
        !pri_gain_valid) else $error("bad");
endmodule : dgcfg_checker
bind dgcfg_regs dgcfg_checker u_chk (.*);

// >>> testbench/dpll_detector_gain_config_tb.sv
// Self-checking bench for the detector gain slice
`timescale 1ns/1ns
module dpll_detector_gain_config_tb;
    logic clock = 0, rst = 1, clk_en = 1, wr_en = 0, rd_en = 0, sv, pv, sgs, pgs;
    logic [6:0] addr = 0;
    logic [7:0] wr_data = 0, rd_data, phase_shift_low, s, p;
    logic [3:0] md = 0;
    logic [2:0] sg, pg;
    int bad_count = 0, n_checks = 0, seed = 17786, i, j;
    dgcfg_regs dut (.clock, .rst, .clk_en, .addr, .wr_en, .rd_en, .wr_data,
        .rd_data, .sec_analog_mode(md[3]), .sec_ref_above_8k(md[2]),
        .pri_analog_mode(md[1]), .pri_ref_above_8k(md[0]),
        .secondary_gain_select_on(sgs), .primary_gain_select_on(pgs),
        .sec_gain_valid(sv), .sec_gain(sg), .pri_gain_valid(pv),
        .pri_gain(pg), .phase_shift_low);
    function automatic logic [3:0] eg(logic [7:0] r, logic an, hi);
        if (!r[7] || (an && !hi)) return 4'h0;
        return {1'b1, an ? r[6:4] : r[2:0]};
    endfunction : eg
    task automatic chk(logic [7:0] g, e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic acc(logic w, logic [6:0] a, logic [7:0] d);
        @(negedge clock); addr = a; wr_en = w; rd_en = !w; wr_data = d;
        @(negedge clock); wr_en = 0; rd_en = 0;
    endtask : acc
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    initial forever #5 clock = ~clock;
    // Whole run needs about 11k ns
    initial begin #200000; bad_count++; stop_test; end
    initial begin
        repeat (12) @(negedge clock); rst = 0;
        acc(0, 7'h6C, 0); chk(rd_data, 8'hC2);
        acc(0, 7'h11, 0); chk(rd_data, 8'h00);
        acc(0, 7'h6D, 0); chk(rd_data, 8'hC2);
        acc(0, 7'h70, 0); chk(rd_data, 8'h00);
        $display("reset test done");
        for (i = 0; i < 40; i++) begin
            s = $random(seed); p = $random(seed);
            if (i < 2) begin s[7] = i[0]; p[7] = i[0]; end
            acc(1, 7'h6C, s); acc(1, 7'h6D, p); acc(1, 7'h70, p);
            // Frozen cycle must drop the write
            clk_en = 0; acc(1, 7'h6C, ~s); clk_en = 1;
            acc(0, 7'h6C, 0); chk(rd_data, s);
            chk(phase_shift_low, p);
            for (j = 0; j < 16; j++) begin
                @(negedge clock); md = j[3:0]; #1;
                chk({sv, sg}, eg(s, md[3], md[2]));
                chk({pv, pg}, eg(p, md[1], md[0]));
            end
        end
        $display("gain test done");
        // Mid-run reset must restore defaults
        @(negedge clock); rst = 1;
        repeat (2) @(negedge clock); rst = 0;
        acc(0, 7'h6D, 0); chk(rd_data, 8'hC2);
        chk(phase_shift_low, 8'h00);
        $display("mid reset test done");
        stop_test;
    end
endmodule : dpll_detector_gain_config_tb
